// ===== logic/asw_params.svh
// Timing constants for the asynchronous memory write port controller
`ifndef ASW_PARAMS_SVH
`define ASW_PARAMS_SVH

// ---------------------------------------------------------------
// Clock
// ---------------------------------------------------------------
`define ASW_CLK_PERIOD_NS               100

// ---------------------------------------------------------------
// Pin timing in ns, as specified
// ---------------------------------------------------------------
`define ASW_ADDRESS_SETUP_TO_START_NS   0
`define ASW_WRITE_STROBE_MIN_WIDTH_NS   20
`define ASW_CONTROL_TO_END_NS           20
`define ASW_ADDRESS_VALID_TO_END_NS     20
`define ASW_WRITE_DATA_SETUP_TO_END_NS  15
`define ASW_WRITE_DATA_HOLD_AFTER_END_NS 0
`define ASW_ADDRESS_HOLD_AFTER_END_NS   0
`define ASW_MIN_INACTIVE_BETWEEN_WRITES_NS 5
`define ASW_MIN_WRITE_CYCLE_TIME_NS     25
`define ASW_WRITE_START_TO_OUTPUT_FLOAT_NS 10

// ---------------------------------------------------------------
// Cycle counts: minimums round up, maximums round down, never below 1
// ---------------------------------------------------------------
`define ASW_CYC_UP(ns)   ((((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS) < 1 ? 1 : \
                          (((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS))
`define ASW_CYC_DN(ns)   (((ns) / `ASW_CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `ASW_CLK_PERIOD_NS))

`define ASW_N_ADDR_SETUP   `ASW_CYC_UP(`ASW_ADDRESS_SETUP_TO_START_NS)
`define ASW_N_STROBE_WIDTH `ASW_CYC_UP(`ASW_WRITE_STROBE_MIN_WIDTH_NS)
`define ASW_N_CTRL_TO_END  `ASW_CYC_UP(`ASW_CONTROL_TO_END_NS)
`define ASW_N_ADDR_TO_END  `ASW_CYC_UP(`ASW_ADDRESS_VALID_TO_END_NS)
`define ASW_N_DATA_SETUP   `ASW_CYC_UP(`ASW_WRITE_DATA_SETUP_TO_END_NS)
`define ASW_N_DATA_HOLD    `ASW_CYC_UP(`ASW_WRITE_DATA_HOLD_AFTER_END_NS)
`define ASW_N_ADDR_HOLD    `ASW_CYC_UP(`ASW_ADDRESS_HOLD_AFTER_END_NS)
`define ASW_N_INACTIVE     `ASW_CYC_UP(`ASW_MIN_INACTIVE_BETWEEN_WRITES_NS)
`define ASW_N_CYCLE        `ASW_CYC_UP(`ASW_MIN_WRITE_CYCLE_TIME_NS)
`define ASW_N_FLOAT        `ASW_CYC_DN(`ASW_WRITE_START_TO_OUTPUT_FLOAT_NS)

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define ASW_ADDR_W         15
`define ASW_DATA_W         8
`define ASW_CNT_W          8
`define ASW_ADDR_RST       15'h0000
`define ASW_DATA_RST       8'h00

`endif

// ===== logic/asw_pkg.sv
// Types shared by the memory write port controller
`default_nettype none
package asw_pkg;

  // -------------------------------------------------------------
  // Which control pin opens and closes the write window
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    ASW_MODE_STROBE = 2'b00,
    ASW_MODE_SELECT = 2'b01,
    ASW_MODE_ENABLE = 2'b10
  } asw_mode_e;

  // -------------------------------------------------------------
  // Write sequence states
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    ASW_ST_IDLE    = 3'b000,
    ASW_ST_SETUP   = 3'b001,
    ASW_ST_FLOAT   = 3'b010,
    ASW_ST_DRIVE   = 3'b011,
    ASW_ST_HOLD    = 3'b100,
    ASW_ST_RECOVER = 3'b101
  } asw_state_e;

endpackage : asw_pkg
`default_nettype wire

// ===== logic/asw_phase_timer.sv
// Down counter that times each phase of the write sequence
`timescale 1ns/1ps
`default_nettype none
`include "asw_params.svh"

module asw_phase_timer (
  input  wire logic                  clock,    // 10 MHz clock
  input  wire logic                  rst_n,    // Async reset, active low
  input  wire logic                  load,     // Start a new phase
  input  wire logic [`ASW_CNT_W-1:0] load_val, // Phase length in cycles
  output wire logic                  last      // Current cycle ends the phase
);

  logic [`ASW_CNT_W-1:0] cnt_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  // A count of zero or one both end the phase, so a zero load cannot stall
  assign last = (cnt_r <= 8'h01);

endmodule : asw_phase_timer
`default_nettype wire

// ===== logic/asw_write_ctrl.sv
// Host-side write controller for an asynchronous 32K x 8 static memory
`timescale 1ns/1ps
`default_nettype none
`include "asw_params.svh"

module asw_write_ctrl
  import asw_pkg::*;
(
  input  wire logic                   clock,                 // 10 MHz clock
  input  wire logic                   rst_n,                 // Async reset, active low
  input  wire logic                   req,                   // Write request
  input  wire logic [`ASW_ADDR_W-1:0] req_addr,              // Write address
  input  wire logic [`ASW_DATA_W-1:0] req_data,              // Write data
  input  wire logic [1:0]             req_mode,              // Controlling pin
  output logic                        ready,                 // Request taken when high
  output logic                        done,                  // Write finished pulse
  output logic [`ASW_ADDR_W-1:0]      sram_addr,             // Address pins
  output logic [`ASW_DATA_W-1:0]      dq_out,                // Data pin output value
  output logic                        dq_oe_n,               // Data driver on, low
  output logic                        write_strobe_low,      // Write strobe pin
  output logic                        select_low,            // Select pin
  output logic                        chip_enable,           // Enable pin, high
  output logic                        output_drive_gate_low  // Output gate pin
);

  // ---------------------------------------------------------------
  // Phase lengths
  // ---------------------------------------------------------------
  function automatic int unsigned max2(input int unsigned a, input int unsigned b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  localparam int unsigned N_WIN = max2(max2(`ASW_N_STROBE_WIDTH, `ASW_N_CTRL_TO_END),
                                       max2(`ASW_N_ADDR_TO_END, `ASW_N_CYCLE));
  localparam int unsigned N_DRV = max2(`ASW_N_DATA_SETUP,
                                       (N_WIN > `ASW_N_FLOAT) ? N_WIN - `ASW_N_FLOAT : 1);
  localparam int unsigned N_HLD = max2(`ASW_N_DATA_HOLD, `ASW_N_ADDR_HOLD);

  // ---------------------------------------------------------------
  // State and registers
  // ---------------------------------------------------------------
  asw_state_e                st_r, st_nxt;
  asw_mode_e                 mode_r;
  logic [`ASW_ADDR_W-1:0]    addr_r;
  logic [`ASW_DATA_W-1:0]    data_r;
  logic                      ready_r, done_r, oe_n_r;
  logic                      wstb_r, sel_r, en_r;
  logic                      last;
  logic                      load;
  logic [`ASW_CNT_W-1:0]     load_val;

  wire  logic accept   = req && ready_r;
  wire  logic in_win   = (st_nxt == ASW_ST_FLOAT) || (st_nxt == ASW_ST_DRIVE);
  wire  logic in_seq   = (st_nxt != ASW_ST_IDLE);
  wire  asw_mode_e req_mode_e = (req_mode == 2'b01) ? ASW_MODE_SELECT :
                                (req_mode == 2'b10) ? ASW_MODE_ENABLE : ASW_MODE_STROBE;
  wire  asw_mode_e mode_nxt   = accept ? req_mode_e : mode_r;

  // The chosen pin toggles per write; the other two stay active for the whole
  // sequence, so only one edge ever opens and one ever closes the window.
  wire  logic wstb_nxt = (mode_nxt == ASW_MODE_STROBE) ? !in_win : !in_seq;
  wire  logic sel_nxt  = (mode_nxt == ASW_MODE_SELECT) ? !in_win : !in_seq;
  wire  logic en_nxt   = (mode_nxt == ASW_MODE_ENABLE) ?  in_win :  in_seq;
  // Data driver on from the end of the float wait through the hold phase
  wire  logic oe_n_nxt = !((st_nxt == ASW_ST_DRIVE) || (st_nxt == ASW_ST_HOLD));

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    load     = 1'b0;
    load_val = 8'h01;
    case (st_r)
      ASW_ST_IDLE: begin
        if (accept) begin
          st_nxt   = ASW_ST_SETUP;
          load     = 1'b1;
          load_val = 8'(`ASW_N_ADDR_SETUP);
        end
      end
      ASW_ST_SETUP: begin
        if (last) begin
          st_nxt   = ASW_ST_FLOAT;
          load     = 1'b1;
          load_val = 8'(`ASW_N_FLOAT);
        end
      end
      ASW_ST_FLOAT: begin
        if (last) begin
          st_nxt   = ASW_ST_DRIVE;
          load     = 1'b1;
          load_val = 8'(N_DRV);
        end
      end
      ASW_ST_DRIVE: begin
        if (last) begin
          st_nxt   = ASW_ST_HOLD;
          load     = 1'b1;
          load_val = 8'(N_HLD);
        end
      end
      ASW_ST_HOLD: begin
        if (last) begin
          st_nxt   = ASW_ST_RECOVER;
          load     = 1'b1;
          load_val = 8'(`ASW_N_INACTIVE);
        end
      end
      ASW_ST_RECOVER: begin
        if (last) begin
          st_nxt = ASW_ST_IDLE;
        end
      end
      default: begin
        st_nxt = ASW_ST_IDLE;
      end
    endcase
  end

  asw_phase_timer u_timer (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (load_val),
    .last     (last)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= ASW_ST_IDLE;
      mode_r  <= ASW_MODE_STROBE;
      ready_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      mode_r  <= mode_nxt;
      ready_r <= (st_nxt == ASW_ST_IDLE) && !accept;
      done_r  <= (st_nxt == ASW_ST_RECOVER) && (st_r == ASW_ST_HOLD);
    end
  end

  // Address and data change only on acceptance, so they stand through the hold
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= `ASW_ADDR_RST;
      data_r <= `ASW_DATA_RST;
    end else if (accept) begin
      addr_r <= req_addr;
      data_r <= req_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wstb_r <= 1'b1;
      sel_r  <= 1'b1;
      en_r   <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      wstb_r <= wstb_nxt;
      sel_r  <= sel_nxt;
      en_r   <= en_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign ready                 = ready_r;
  assign done                  = done_r;
  assign sram_addr             = addr_r;
  assign dq_out                = data_r;
  assign dq_oe_n               = oe_n_r;
  assign write_strobe_low      = wstb_r;
  assign select_low            = sel_r;
  assign chip_enable           = en_r;
  // The controller never reads, so the memory outputs are kept floating
  assign output_drive_gate_low = 1'b1;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  wire logic wr_on = !write_strobe_low && !select_low && chip_enable;

  a_addr_before_start: assert property ($rose(wr_on) |-> $stable(sram_addr))
    else $error("Address changed as the write window opened");
  a_addr_in_window: assert property (wr_on |-> $stable(sram_addr))
    else $error("Address changed inside the write window");
  a_addr_after_end: assert property ($fell(wr_on) |-> $stable(sram_addr))
    else $error("Address changed as the write window closed");
  a_data_setup_end: assert property ($fell(wr_on) |-> $past(!dq_oe_n, 1))
    else $error("Data not driven before end of write");
  a_data_hold_end: assert property ($fell(wr_on) |-> !dq_oe_n && $stable(dq_out))
    else $error("Data not held after end of write");
  a_drive_after_float: assert property ($fell(dq_oe_n) |-> $past(wr_on, 1) && wr_on)
    else $error("Data driven before memory output floated");
  a_window_width: assert property ($rose(wr_on) |-> wr_on [*2])
    else $error("Write window shorter than two cycles");
  a_gap_between: assert property ($fell(wr_on) |-> !wr_on [*3])
    else $error("Write window reopened too soon");
  a_others_held: assert property (wr_on && (mode_r == ASW_MODE_STROBE)
                                  |=> !select_low && chip_enable)
    else $error("Select or enable dropped during strobe write");
  a_deselect_gap: assert property ($fell(wr_on) && (mode_r == ASW_MODE_SELECT)
                                   |-> select_low)
    else $error("Select write did not deselect at end");
  a_done_after: assert property ($fell(wr_on) |-> ##1 done)
    else $error("Done not pulsed after write");

  c_strobe_write: cover property ($fell(wr_on) && mode_r == ASW_MODE_STROBE);
  c_select_write: cover property ($fell(wr_on) && mode_r == ASW_MODE_SELECT);
  c_enable_write: cover property ($fell(wr_on) && mode_r == ASW_MODE_ENABLE);
  c_back_to_back: cover property (done ##[1:4] $rose(wr_on));

endmodule : asw_write_ctrl
`default_nettype wire

// ===== tb/asw_sram_model.sv
// Behavioural model of the asynchronous static memory on the far side of the write controller
`timescale 1ns/1ps
`default_nettype none
`include "asw_params.svh"

module asw_sram_model (
  input  wire logic [`ASW_ADDR_W-1:0] sram_addr,             // Address pins
  input  wire logic [`ASW_DATA_W-1:0] dq_bus,                // Resolved data wire
  input  wire logic                   write_strobe_low,      // Write strobe, low
  input  wire logic                   select_low,            // Select, low
  input  wire logic                   chip_enable,           // Enable, high
  input  wire logic                   output_drive_gate_low, // Output gate, low
  output logic [`ASW_ADDR_W-1:0]      last_addr,             // Address of last write
  output logic [`ASW_DATA_W-1:0]      last_data,             // Byte stored by last write
  output logic [1:0]                  end_pin,               // Pin that closed the window
  output logic                        q_oe,                  // Memory drives data pins
  output int unsigned                 n_write,               // Writes completed
  output int unsigned                 n_err                  // Host timing faults seen
);
  // ---------------------------------------------------------------
  // Write window and storage
  // ---------------------------------------------------------------
  logic [`ASW_DATA_W-1:0] mem [logic [`ASW_ADDR_W-1:0]];
  realtime t_open, t_end, t_data, t_addr;
  bit seen_open;
  bit is_open;
  wire logic win = !write_strobe_low && !select_low && chip_enable;
  // Never drives during a write or while deselected; gate high keeps it floating
  assign q_oe = !output_drive_gate_low && !win && !select_low && chip_enable;

  initial begin
    n_write = 0;
    n_err = 0;
    seen_open = 0;
    t_end = 0.0;
  end

  always @(dq_bus) t_data = $realtime;
  always @(sram_addr) begin
    t_addr = $realtime;
    if (win) n_err++;
  end
  always @(posedge win) begin
    if (seen_open && ($realtime - t_open < 25.0)) n_err++;
    if (seen_open && ($realtime - t_end < 5.0)) n_err++;
    t_open = $realtime;
    seen_open = 1;
    is_open = 1;
  end
  // Data is captured when the window closes, so late data is a host fault.
  // Only a window that really opened counts: the unknown-to-low settle at reset is no write.
  always @(negedge win) begin
    if (is_open) begin
      is_open = 0;
      if ($realtime - t_open < 20.0) n_err++;
      if ($realtime - t_data < 15.0) n_err++;
      if ($realtime - t_addr < 20.0) n_err++;
      mem[sram_addr] = dq_bus;
      last_addr = sram_addr;
      last_data = dq_bus;
      end_pin = write_strobe_low ? 2'd0 : (select_low ? 2'd1 : 2'd2);
      t_end = $realtime;
      n_write++;
    end
  end
endmodule : asw_sram_model
`default_nettype wire

// ===== tb/tb_async_sram_write_port.sv
// Self-checking testbench for the memory write port controller
`timescale 1ns/1ps
`default_nettype none
`include "asw_params.svh"

module tb_async_sram_write_port;
  typedef struct {logic [1:0] mode; logic [14:0] addr; logic [7:0] data; int take;} asw_exp_s;
  logic        clock, rst_n, req;
  logic [14:0] req_addr, sram_addr, last_addr;
  logic [7:0]  req_data, dq_out, dq_bus, last_data;
  logic [1:0]  req_mode, end_pin;
  logic        ready, done, dq_oe_n, write_strobe_low, select_low, chip_enable, gate_low, q_oe;
  int unsigned n_write, n_err;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, n_done = 0;
  logic [31:0] seed;
  asw_exp_s    exp_q[$];

  asw_write_ctrl uut (.clock(clock), .rst_n(rst_n), .req(req), .req_addr(req_addr),
    .req_data(req_data), .req_mode(req_mode), .ready(ready), .done(done),
    .sram_addr(sram_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .write_strobe_low(write_strobe_low), .select_low(select_low),
    .chip_enable(chip_enable), .output_drive_gate_low(gate_low));
  // Released bus shows the inverse of the last value so a missing drive is caught
  assign dq_bus = (dq_oe_n === 1'b0) ? dq_out : ~dq_out;
  asw_sram_model mem_m (.sram_addr(sram_addr), .dq_bus(dq_bus),
    .write_strobe_low(write_strobe_low), .select_low(select_low), .chip_enable(chip_enable),
    .output_drive_gate_low(gate_low), .last_addr(last_addr), .last_data(last_data),
    .end_pin(end_pin), .q_oe(q_oe), .n_write(n_write), .n_err(n_err));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Holding req keeps the next request pending while busy, which must be ignored
  task automatic do_write(input logic [1:0] m, input logic [14:0] a, input logic [7:0] d,
                          input bit hold);
    asw_exp_s e;
    int       k;
    k = 0;
    @(posedge clock);
    req      <= 1'b1;
    req_mode <= m;
    req_addr <= a;
    req_data <= d;
    @(negedge clock);
    while (ready !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    @(posedge clock);
    e.mode = (m == 2'b11) ? 2'b00 : m;
    e.addr = a;
    e.data = d;
    e.take = cyc;
    exp_q.push_back(e);
    if (!hold) req <= 1'b0;
  endtask : do_write

  task automatic check_rst;
    check({ready, done, write_strobe_low, select_low, chip_enable, dq_oe_n, gate_low},
          7'b0011011);
    check({sram_addr, dq_out}, 23'h000000);
  endtask : check_rst

  // ---------------------------------------------------------------
  // Result watcher
  // ---------------------------------------------------------------
  always @(negedge clock) begin : watch
    asw_exp_s e;
    if (rst_n === 1'b1) begin
      if (done === 1'b1) begin
        if (exp_q.size() == 0) check(32'h1, 32'h0);
        else begin
          e = exp_q.pop_front();
          n_done++;
          check(last_addr, e.addr);
          check(last_data, e.data);
          check(end_pin, e.mode);
          // Taking edge, four one-cycle phases, then done stands in the fifth cycle
          check(cyc, e.take + 5);
          check(n_write, n_done);
        end
      end
      if (ready === 1'b1) check({write_strobe_low, select_low, chip_enable, dq_oe_n}, 4'hD);
      check(q_oe & ~dq_oe_n, 32'h0);
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    req_addr = 15'h0000;
    req_data = 8'h00;
    req_mode = 2'b00;
    seed = 32'hB1A3;
    repeat (16) @(posedge clock);
    @(negedge clock);
    check_rst();
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      do_write(m[1:0], seed[14:0], seed[22:15], 1'b0);
    end
    $display("test modes done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      do_write(seed[31:30], seed[14:0], seed[22:15], i < 7);
    end
    do_write(2'b01, 15'h7FFF, 8'hFF, 1'b1);
    do_write(2'b10, 15'h0000, 8'h00, 1'b0);
    $display("test back_to_back done");
    seed = lfsr(seed);
    do_write(2'b00, seed[14:0], seed[22:15], 1'b0);
    rst_n <= 1'b0;
    exp_q.delete();
    repeat (3) @(posedge clock);
    @(negedge clock);
    check_rst();
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    do_write(2'b01, 15'h1234, 8'hA5, 1'b0);
    repeat (10) @(posedge clock);
    check(exp_q.size(), 32'h0);
    check(n_err, 32'h0);
    $display("test midrun_reset done");
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_async_sram_write_port
`default_nettype wire
